// ===== src/rts_pkg.sv
// Shared constants and carrier types for the reset time-out sequencer.
package rts_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [3:0] OFS_POWER_STATUS = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_SEQ_STATE = 4'hc;

  // Field positions.
  localparam int BIT_BROWNOUT_FLAG = 0;
  localparam int BIT_POR_FLAG = 1;
  localparam int BIT_PD_FLAG = 3;
  localparam int BIT_TO_FLAG = 4;
  localparam int BIT_SLEEP_CMD = 0;

  // Values after a power-on reset.
  localparam logic POR_FLAG_RESET = 1'b0;
  localparam logic BROWNOUT_FLAG_RESET = 1'b1;
  localparam logic TO_FLAG_RESET = 1'b1;
  localparam logic PD_FLAG_RESET = 1'b1;

  // Program counter start values.
  localparam logic [12:0] PC_RESET_VECTOR = 13'h0000;
  localparam logic [12:0] PC_INT_VECTOR = 13'h0004;

  // Timing: 250 MHz core clock, 72 ms power-up delay, 1024 oscillator edges.
  localparam int CLK_PERIOD_NS = 4;
  localparam int POWER_UP_TIMER_TIME_NS = 72000000;
  localparam int POWER_UP_TIMER_CYCLES = (POWER_UP_TIMER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_DIV_CYCLES = 4;
  localparam int POWER_UP_TIMER_W = 24;
  localparam int OST_CYCLES = 1024;
  localparam int OST_W = 10;
  localparam logic [OST_W-1:0] OST_LAST = 10'h3ff;
  localparam logic [1:0] RC_DIV_LAST = 2'h3;
  localparam int SYNC_W = 8;

  // Oscillator mode encoding of the two configuration bits.
  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL = 2'b00,
    OSC_CRYSTAL = 2'b01,
    OSC_HIGH_SPEED_CRYSTAL = 2'b10,
    OSC_RC = 2'b11
  } rts_osc_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_POWER_UP_TIMER = 3'b001,
    ST_OST = 3'b010,
    ST_WAIT_PIN = 3'b011,
    ST_RUN = 3'b100,
    ST_SLEEP = 3'b101,
    ST_WAKE_OST = 3'b110,
    ST_BOR_HOLD = 3'b111
  } rts_state_t;

  // Configuration bits as they arrive from the fuse array.
  typedef struct packed {
    rts_osc_t osc_mode;
    logic power_timer_enable_n;
    logic brownout_enable_cfg;
  } rts_cfg_t;

  // Same-clock events from the core, watchdog and interrupt logic.
  typedef struct packed {
    logic wdt_timeout;
    logic wake_int;
    logic global_int_enable;
    logic [12:0] pc_next;
  } rts_core_evt_t;

endpackage

// ===== src/rts_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for a group of independent pin levels.
module rts_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // First stage; only the second stage reads it.
  logic [W-1:0] meta_reg;

  // Both stages clear to zero, which reads as a low pin until it settles.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ===== src/rts_stage_counter.sv
`timescale 1ns/10ps
// Delay stage counter: counts step pulses and flags the last one.
module rts_stage_counter #(
  parameter int W = 8,
  parameter logic [W-1:0] LAST = '1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic step,
  output logic [W-1:0] count,
  output logic done
);

  // Done is a one-cycle pulse on the step that completes the stage.
  assign done = step && (count == LAST);

  // Clear dominates so a restarted stage always begins from zero.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (step)
      count <= W'(count + 1'b1);
  end

endmodule

// ===== src/rts_sequencer.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module rts_sequencer #(
  parameter int POWER_UP_TIMER_CYCLES = rts_pkg::POWER_UP_TIMER_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic por_pulse,
  input wire logic brownout_detect,
  input wire logic ext_reset_pin_n,
  input wire logic osc_input,
  input wire rts_pkg::rts_cfg_t cfg,
  input wire rts_pkg::rts_core_evt_t core_evt,
  output logic core_reset,
  output logic core_run,
  output logic pc_load,
  output logic [12:0] pc_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  // Power-up delay length in internal RC ticks.
  localparam logic [rts_pkg::POWER_UP_TIMER_W-1:0] POWER_UP_TIMER_LAST =
    rts_pkg::POWER_UP_TIMER_W'(POWER_UP_TIMER_CYCLES / rts_pkg::RC_DIV_CYCLES - 1);

  logic [rts_pkg::SYNC_W-1:0] sync_vec; // Settled pin levels.
  logic por_s, bod_s, pin_s, osc_s;
  rts_pkg::rts_cfg_t cfg_s; // Settled configuration bits.
  logic por_prev_reg, osc_prev_reg; // Previous settled levels for edges.

  rts_sync #(.W(rts_pkg::SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({por_pulse, brownout_detect, ext_reset_pin_n, osc_input, cfg}),
    .sync_out(sync_vec)
  );

  assign {por_s, bod_s, pin_s, osc_s, cfg_s} = sync_vec;

  // The pulse may last many cycles, so only its leading edge is an event.
  wire por_evt = por_s && !por_prev_reg;
  wire osc_rise = osc_s && !osc_prev_reg;
  wire power_up_timer_en = !cfg_s.power_timer_enable_n;
  wire crystal = (cfg_s.osc_mode != rts_pkg::OSC_RC);
  wire bor_active = cfg_s.brownout_enable_cfg && bod_s;

  // Edge history registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      por_prev_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end
    else
    begin
      por_prev_reg <= por_s;
      osc_prev_reg <= osc_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal RC clock and the two delay stages.

  logic [1:0] rc_div_reg; // Free-running divider standing in for the RC oscillator.
  rts_pkg::rts_state_t state_reg, state_next;
  logic power_up_timer_done, ost_done;
  logic [rts_pkg::POWER_UP_TIMER_W-1:0] power_up_timer_count;
  logic [rts_pkg::OST_W-1:0] ost_count;
  wire rc_tick = (rc_div_reg == rts_pkg::RC_DIV_LAST);
  wire in_ost = (state_reg == rts_pkg::ST_OST) || (state_reg == rts_pkg::ST_WAKE_OST);

  // The RC divider never stops, so the delay does not depend on the crystal.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rc_div_reg <= 2'h0;
    else
      rc_div_reg <= 2'(rc_div_reg + 2'h1);
  end

  // Leaving the stage clears it, so a brown-out re-arms the full delay.
  rts_stage_counter #(.W(rts_pkg::POWER_UP_TIMER_W), .LAST(POWER_UP_TIMER_LAST)) u_power_up_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(state_reg != rts_pkg::ST_POWER_UP_TIMER),
    .step(rc_tick),
    .count(power_up_timer_count),
    .done(power_up_timer_done)
  );

  // Counts settled rising edges of the oscillator input.
  rts_stage_counter #(.W(rts_pkg::OST_W), .LAST(rts_pkg::OST_LAST)) u_ost (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(!in_ost),
    .step(osc_rise),
    .count(ost_count),
    .done(ost_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bus address phase.

  logic dp_write_reg; // Data phase of a write is in progress.
  logic [3:0] dp_addr_reg; // Byte offset of that write.
  logic por_flag_n_reg, brownout_flag_n_reg, to_flag_n_reg, pd_flag_n_reg;
  logic [12:0] target_reg; // Start address for the next release.
  wire addr_ok = hsel && hready && htrans[1];
  wire in_map = (haddr[31:4] == 28'h0);
  wire wr_pstat = dp_write_reg && (dp_addr_reg == rts_pkg::OFS_POWER_STATUS);
  wire sleep_cmd = dp_write_reg && (dp_addr_reg == rts_pkg::OFS_CTRL)
                   && hwdata[rts_pkg::BIT_SLEEP_CMD];
  wire [31:0] rd_pstat = {30'h0, por_flag_n_reg, brownout_flag_n_reg};
  wire [31:0] rd_flags = {27'h0, to_flag_n_reg, pd_flag_n_reg, 3'h0};
  wire [31:0] rd_state = {28'h0, core_reset, state_reg};
  wire [31:0] rd_word =
    !in_map ? 32'h0 :
    (haddr[3:0] == rts_pkg::OFS_POWER_STATUS) ? rd_pstat :
    (haddr[3:0] == rts_pkg::OFS_FLAGS) ? rd_flags :
    (haddr[3:0] == rts_pkg::OFS_SEQ_STATE) ? rd_state : 32'h0;

  // Zero-wait slave: read data is fetched in the address phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 4'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      dp_write_reg <= addr_ok && hwrite && in_map;
      dp_addr_reg <= haddr[3:0];
      hrdata <= (addr_ok && !hwrite) ? rd_word : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: stages, causes and flags.

  logic por_next, bor_next, to_next, pd_next;
  logic [12:0] target_next;
  // Stage after a power-on or brown-out: delay, then crystal count, then pin.
  wire rts_pkg::rts_state_t first_stage =
    power_up_timer_en ? rts_pkg::ST_POWER_UP_TIMER : (crystal ? rts_pkg::ST_OST : rts_pkg::ST_WAIT_PIN);
  wire rts_pkg::rts_state_t after_power_up_timer =
    crystal ? rts_pkg::ST_OST : rts_pkg::ST_WAIT_PIN;
  wire rts_pkg::rts_state_t wake_stage =
    crystal ? rts_pkg::ST_WAKE_OST : rts_pkg::ST_RUN;
  wire [12:0] int_target =
    core_evt.global_int_enable ? rts_pkg::PC_INT_VECTOR : core_evt.pc_next;

  // Later assignments take priority: pin and watchdog, then brown-out, then power-on.
  always_comb
  begin
    state_next = state_reg;
    por_next = por_flag_n_reg;
    bor_next = brownout_flag_n_reg;
    to_next = to_flag_n_reg;
    pd_next = pd_flag_n_reg;
    target_next = target_reg;
    // Software may only write the status bits; a hardware clear below wins.
    if (wr_pstat)
    begin
      por_next = hwdata[rts_pkg::BIT_POR_FLAG];
      bor_next = hwdata[rts_pkg::BIT_BROWNOUT_FLAG];
    end
    case (state_reg)
      rts_pkg::ST_HOLD:
        state_next = rts_pkg::ST_HOLD;
      rts_pkg::ST_POWER_UP_TIMER:
        if (power_up_timer_done)
          state_next = after_power_up_timer;
      rts_pkg::ST_OST:
        if (ost_done)
          state_next = rts_pkg::ST_WAIT_PIN;
      // Stages may already be over while the pin is low; release is immediate.
      rts_pkg::ST_WAIT_PIN:
        if (pin_s)
          state_next = rts_pkg::ST_RUN;
      rts_pkg::ST_RUN:
        if (!pin_s)
        begin
          state_next = rts_pkg::ST_WAIT_PIN;
          target_next = rts_pkg::PC_RESET_VECTOR;
        end
        else if (core_evt.wdt_timeout)
        begin
          // Internal reset only; the pin is an input and is never driven.
          state_next = rts_pkg::ST_WAIT_PIN;
          to_next = 1'b0;
          pd_next = 1'b1;
          target_next = rts_pkg::PC_RESET_VECTOR;
        end
        else if (sleep_cmd)
        begin
          state_next = rts_pkg::ST_SLEEP;
          to_next = 1'b1;
          pd_next = 1'b0;
        end
      rts_pkg::ST_SLEEP:
        if (!pin_s)
        begin
          state_next = rts_pkg::ST_WAIT_PIN;
          to_next = 1'b1;
          pd_next = 1'b0;
          target_next = rts_pkg::PC_RESET_VECTOR;
        end
        else if (core_evt.wdt_timeout)
        begin
          state_next = wake_stage;
          to_next = 1'b0;
          pd_next = 1'b0;
          target_next = core_evt.pc_next;
        end
        else if (core_evt.wake_int)
        begin
          state_next = wake_stage;
          to_next = 1'b1;
          pd_next = 1'b0;
          target_next = int_target;
        end
      rts_pkg::ST_WAKE_OST:
        if (!pin_s)
        begin
          state_next = rts_pkg::ST_WAIT_PIN;
          to_next = 1'b1;
          pd_next = 1'b0;
          target_next = rts_pkg::PC_RESET_VECTOR;
        end
        else if (ost_done)
          state_next = rts_pkg::ST_RUN;
      rts_pkg::ST_BOR_HOLD:
        if (!bor_active)
          state_next = first_stage;
      default:
        state_next = rts_pkg::ST_HOLD;
    endcase
    // A brown-out overrides every stage and restarts the sequence later.
    if (bor_active)
    begin
      state_next = rts_pkg::ST_BOR_HOLD;
      bor_next = 1'b0;
      to_next = 1'b1;
      pd_next = 1'b1;
      target_next = rts_pkg::PC_RESET_VECTOR;
    end
    if (por_evt)
    begin
      state_next = bor_active ? rts_pkg::ST_BOR_HOLD : first_stage;
      por_next = rts_pkg::POR_FLAG_RESET;
      if (cfg_s.brownout_enable_cfg)
        bor_next = rts_pkg::BROWNOUT_FLAG_RESET;
      to_next = rts_pkg::TO_FLAG_RESET;
      pd_next = rts_pkg::PD_FLAG_RESET;
      target_next = rts_pkg::PC_RESET_VECTOR;
    end
  end

  // The core stays stalled but not reset while it sleeps or waits on the crystal after a wake.
  wire reset_next = !((state_next == rts_pkg::ST_RUN) || (state_next == rts_pkg::ST_SLEEP)
                      || (state_next == rts_pkg::ST_WAKE_OST));
  wire enter_run = (state_next == rts_pkg::ST_RUN) && (state_reg != rts_pkg::ST_RUN);

  // State, flags and registered core-facing outputs.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= rts_pkg::ST_HOLD;
      por_flag_n_reg <= rts_pkg::POR_FLAG_RESET;
      brownout_flag_n_reg <= rts_pkg::BROWNOUT_FLAG_RESET;
      to_flag_n_reg <= rts_pkg::TO_FLAG_RESET;
      pd_flag_n_reg <= rts_pkg::PD_FLAG_RESET;
      target_reg <= rts_pkg::PC_RESET_VECTOR;
      core_reset <= 1'b1;
      core_run <= 1'b0;
      pc_load <= 1'b0;
      pc_start <= rts_pkg::PC_RESET_VECTOR;
    end
    else
    begin
      state_reg <= state_next;
      por_flag_n_reg <= por_next;
      brownout_flag_n_reg <= bor_next;
      to_flag_n_reg <= to_next;
      pd_flag_n_reg <= pd_next;
      target_reg <= target_next;
      core_reset <= reset_next;
      core_run <= (state_next == rts_pkg::ST_RUN);
      pc_load <= enter_run;
      pc_start <= enter_run ? target_next : pc_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_power_up_timer_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == rts_pkg::ST_POWER_UP_TIMER) |-> core_reset)
    else $error("Core left reset during the power-up delay.");

  chk_power_up_timer_skipped: assert property (@(posedge hclk) disable iff (!hresetn)
    (por_evt && !bor_active && !power_up_timer_en) |=> (state_reg != rts_pkg::ST_POWER_UP_TIMER))
    else $error("Disabled power-up delay was entered.");

  chk_ost_length: assert property (@(posedge hclk) disable iff (!hresetn)
    ost_done |-> (ost_count == rts_pkg::OST_LAST) && in_ost)
    else $error("Oscillator count ended at the wrong edge.");

  chk_ost_crystal: assert property (@(posedge hclk) disable iff (!hresetn)
    (!in_ost && (state_next == rts_pkg::ST_OST || state_next == rts_pkg::ST_WAKE_OST))
    |-> crystal)
    else $error("Oscillator count started in RC mode.");

  chk_bor_enters: assert property (@(posedge hclk) disable iff (!hresetn)
    (bor_active && !por_evt) |=> (state_reg == rts_pkg::ST_BOR_HOLD) && !brownout_flag_n_reg
    && core_reset)
    else $error("Brown-out did not force reset.");

  chk_pin_release: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == rts_pkg::ST_WAIT_PIN && pin_s && !bor_active && !por_evt)
    |=> (state_reg == rts_pkg::ST_RUN) && !core_reset && pc_load)
    else $error("Pin release did not start execution at once.");

  chk_por_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    por_evt |=> !por_flag_n_reg && to_flag_n_reg && pd_flag_n_reg)
    else $error("Power-on flags wrong.");

  chk_wdt_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == rts_pkg::ST_RUN && pin_s && core_evt.wdt_timeout && !bor_active
    && !por_evt) |=> !to_flag_n_reg && pd_flag_n_reg ##1 !core_reset)
    else $error("Watchdog reset flags or release wrong.");

  chk_int_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == rts_pkg::ST_SLEEP && pin_s && !core_evt.wdt_timeout && core_evt.wake_int
    && core_evt.global_int_enable && !crystal && !bor_active && !por_evt)
    |=> pc_load && (pc_start == rts_pkg::PC_INT_VECTOR))
    else $error("Interrupt wake did not load the vector.");

  chk_release_cond: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(core_reset) |-> $past(pin_s) && !$past(bor_active))
    else $error("Reset released with pin low or brown-out active.");

endmodule

// ===== bench/rts_supply_model.sv
`timescale 1ns/10ps
// Supply detectors, external reset pin and crystal, as seen at the device pins.
module rts_supply_model (
  input wire logic hclk,
  output logic por_pulse,
  output logic brownout_detect,
  output logic ext_reset_pin_n,
  output logic osc_input
);
  // Quiet supply and a released pin at time zero.
  initial
  begin
    por_pulse = 1'b0;
    brownout_detect = 1'b0;
    ext_reset_pin_n = 1'b1;
    osc_input = 1'b0;
  end
  // The oscillator runs free at 50 MHz, so each edge survives the synchroniser.
  // It starts 1 ns late so that none of its edges meets a clock edge.
  initial
  begin
    #1;
    forever #10 osc_input = ~osc_input;
  end
  // A four-cycle pulse, long enough to cross the two-flop synchroniser.
  task automatic power_on();
    @(posedge hclk);
    por_pulse <= 1'b1;
    repeat (4) @(posedge hclk);
    por_pulse <= 1'b0;
  endtask
  // A low supply keeps the device in reset until it recovers.
  task automatic supply_low(input logic low);
    @(posedge hclk);
    brownout_detect <= low;
  endtask
  // The external pin is a plain level that the system pulls low or releases.
  task automatic pin(input logic level);
    @(posedge hclk);
    ext_reset_pin_n <= level;
  endtask
endmodule

// ===== bench/reset_timeout_sequencer_test.sv
`timescale 1ns/10ps
// Bench for the reset time-out sequencer.
module reset_timeout_sequencer_test;
  typedef struct packed {logic [1:0] mode; logic power_up_timer_n; int lo;} rts_row_t;
  // Crystal modes add 1024 periods of five cycles; the enabled delay adds 40 cycles.
  localparam rts_row_t ROWS [8] = '{'{2'h0, 1'b0, 5160}, '{2'h1, 1'b0, 5160},
    '{2'h2, 1'b0, 5160}, '{2'h3, 1'b0, 40}, '{2'h0, 1'b1, 5120}, '{2'h1, 1'b1, 5120},
    '{2'h2, 1'b1, 5120}, '{2'h3, 1'b1, 0}};
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic por_pulse;
  logic brownout_detect;
  logic ext_reset_pin_n;
  logic osc_input;
  rts_pkg::rts_cfg_t cfg;
  rts_pkg::rts_core_evt_t core_evt;
  logic core_reset;
  logic core_run;
  logic pc_load;
  logic [12:0] pc_start;
  logic [31:0] rd_q;
  logic rdy_q;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  rts_row_t r;
  ////////////////////////////////////////////////////////////////////////////////
  always #2 hclk = ~hclk;
  // Bus answers are captured at the edge itself, before that edge's updates land.
  always @(posedge hclk)
  begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
  end
  // The power-up delay is cut to 10 ticks so that each run stays short.
  rts_sequencer #(.POWER_UP_TIMER_CYCLES(40)) rts_sequencer_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .por_pulse(por_pulse), .brownout_detect(brownout_detect),
    .ext_reset_pin_n(ext_reset_pin_n), .osc_input(osc_input), .cfg(cfg),
    .core_evt(core_evt), .core_reset(core_reset), .core_run(core_run),
    .pc_load(pc_load), .pc_start(pc_start));
  rts_supply_model rts_supply_model_i (.hclk(hclk), .por_pulse(por_pulse),
    .brownout_detect(brownout_detect), .ext_reset_pin_n(ext_reset_pin_n),
    .osc_input(osc_input));
  ////////////////////////////////////////////////////////////////////////////////
  // One comparison; four-state equality so an unknown never matches.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single AHB-Lite transfer; the request holds until ready is sampled high.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    #1;
    while (rdy_q !== 1'b1)
    begin
      @(posedge hclk);
      #1;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    #1;
    while (rdy_q !== 1'b1)
    begin
      @(posedge hclk);
      #1;
    end
    rd = rd_q;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(d, exp);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask
  // Counts cycles until the core runs; the bound keeps a stuck reset from hanging.
  task automatic wait_run(output int cnt);
    cnt = 0;
    @(negedge hclk);
    while (core_run !== 1'b1 && cnt < 20000)
    begin
      @(negedge hclk);
      cnt++;
    end
    // A core that never starts is a failure in its own right.
    if (cnt >= 20000)
      err_count++;
  endtask
  task automatic results();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the full run needs about 147 microseconds of simulated time.
  initial
  begin
    #250us;
    err_count++;
    results();
  end
  // Main sequence: table of power-up cases, then hand-written awkward cases.
  initial
  begin
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    cfg <= '{rts_pkg::OSC_LOW_POWER_CRYSTAL, 1'b0, 1'b1};
    core_evt <= '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdchk(32'h10, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      r = ROWS[i];
      @(posedge hclk);
      // Brown-out reset is only enabled together with the power-up delay.
      cfg <= '{rts_pkg::rts_osc_t'(r.mode), r.power_up_timer_n, !r.power_up_timer_n};
      repeat (3) @(posedge hclk);
      rts_supply_model_i.power_on();
      wait_run(n);
      // Tick and oscillator phase can each shorten a stage by a few cycles.
      check(32'(n >= r.lo - 8 && n <= r.lo + 4), 32'h1);
      check({19'h0, pc_start}, 32'h0);
      check({31'h0, pc_load}, 32'h1);
      rdchk(32'h0, 32'h1);
      rdchk(32'h4, 32'h18);
      wr(32'h0, 32'h3);
      rdchk(32'h0, 32'h3);
    end
    // Watchdog reset in normal operation restarts at zero with time-out cleared.
    @(posedge hclk);
    cfg <= '{rts_pkg::OSC_RC, 1'b0, 1'b1};
    rdchk(32'hc, 32'h4);
    core_evt.pc_next <= 13'h0123;
    core_evt.wdt_timeout <= 1'b1;
    @(posedge hclk);
    core_evt.wdt_timeout <= 1'b0;
    wait_run(n);
    check({19'h0, pc_start}, 32'h0);
    wr(32'h4, 32'h0);
    rdchk(32'h4, 32'h08);
    // Pin low in normal operation holds the core; flags stay as they were.
    rts_supply_model_i.pin(1'b0);
    repeat (6) @(negedge hclk);
    check({31'h0, core_reset}, 32'h1);
    rts_supply_model_i.pin(1'b1);
    wait_run(n);
    rdchk(32'h4, 32'h08);
    // Sleep, then an interrupt wake with the global enable goes to the vector.
    wr(32'h8, 32'h1);
    repeat (3) @(negedge hclk);
    check({31'h0, core_run}, 32'h0);
    @(posedge hclk);
    core_evt.global_int_enable <= 1'b1;
    core_evt.wake_int <= 1'b1;
    @(posedge hclk);
    core_evt.wake_int <= 1'b0;
    wait_run(n);
    check({19'h0, pc_start}, 32'h4);
    rdchk(32'h4, 32'h10);
    // Sleep again; a watchdog wake continues at the next address.
    wr(32'h8, 32'h1);
    repeat (3) @(posedge hclk);
    core_evt.wdt_timeout <= 1'b1;
    @(posedge hclk);
    core_evt.wdt_timeout <= 1'b0;
    wait_run(n);
    check({19'h0, pc_start}, 32'h0123);
    rdchk(32'h4, 32'h0);
    // In a crystal mode a wake runs the full oscillator count first.
    @(posedge hclk);
    cfg <= '{rts_pkg::OSC_CRYSTAL, 1'b0, 1'b1};
    wr(32'h8, 32'h1);
    repeat (3) @(posedge hclk);
    core_evt.wdt_timeout <= 1'b1;
    @(posedge hclk);
    core_evt.wdt_timeout <= 1'b0;
    wait_run(n);
    check(32'(n >= 5112 && n <= 5124), 32'h1);
    @(posedge hclk);
    cfg <= '{rts_pkg::OSC_RC, 1'b0, 1'b1};
    // Brown-out, recovery, a second dip inside the delay: the delay starts again.
    rts_supply_model_i.supply_low(1'b1);
    repeat (100) @(negedge hclk);
    check({31'h0, core_reset}, 32'h1);
    rts_supply_model_i.supply_low(1'b0);
    repeat (20) @(posedge hclk);
    rts_supply_model_i.supply_low(1'b1);
    repeat (10) @(posedge hclk);
    rts_supply_model_i.supply_low(1'b0);
    wait_run(n);
    check(32'(n >= 38 && n <= 56), 32'h1);
    rdchk(32'h0, 32'h2);
    rdchk(32'h4, 32'h18);
    // With brown-out disabled a low supply must not reset the core.
    @(posedge hclk);
    cfg <= '{rts_pkg::OSC_RC, 1'b0, 1'b0};
    rts_supply_model_i.supply_low(1'b1);
    repeat (50) @(negedge hclk);
    check({31'h0, core_run}, 32'h1);
    rts_supply_model_i.supply_low(1'b0);
    // Time-outs expire while the pin is low; its release starts at once.
    rts_supply_model_i.pin(1'b0);
    rts_supply_model_i.power_on();
    repeat (200) @(negedge hclk);
    check({31'h0, core_run}, 32'h0);
    rdchk(32'hc, 32'hb);
    rts_supply_model_i.pin(1'b1);
    wait_run(n);
    check(32'(n <= 6), 32'h1);
    // A second bus reset in mid-run puts the core back into reset.
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    check({31'h0, core_reset}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    // Back in the hold state with the core in reset until a power-on edge.
    rdchk(32'hc, 32'h8);
    results();
  end
endmodule
